// >>> hdl/dcw_pkg.sv
package dcw_pkg;
    // profile selection value that enables pass-through decoding
    localparam logic [7:0] PROFILE_PASS_THRU = 8'h05;
    // command word field positions
    localparam int BIT_STOP      = 0;
    localparam int BIT_START     = 1;
    localparam int BIT_REVERSE   = 2;
    localparam int BIT_RESET     = 4;
    localparam int BIT_LOC2      = 5;
    localparam int BIT_RUN_DIS   = 6;
    localparam int BIT_STOP_RAMP = 7;
    localparam int BIT_STOP_EMER = 8;
    localparam int BIT_STOP_FREE = 9;
    localparam int BIT_RAMP_SET  = 10;
    localparam int BIT_OUT_ZERO  = 11;
    localparam int BIT_HOLD      = 12;
    localparam int BIT_IN_ZERO   = 13;
    localparam int BIT_LOC_LOCK  = 14;
    localparam int BIT_CTL_TAKE  = 16;
    localparam int BIT_REF_TAKE  = 17;
    localparam int BIT_USER_LO   = 22;
    // mask of defined bits; reserved 3, 18-21, 26-31 are dropped
    localparam logic [31:0] CMD_USED_MASK = 32'h03c3_fff7;
    localparam logic [31:0] CMD_RESET_VAL = 32'h0000_0000;
    // stop mode encodings
    typedef enum logic [1:0] {
        DCW_STOP_PARAM,
        DCW_STOP_RAMP,
        DCW_STOP_EMER,
        DCW_STOP_FREE
    } dcw_stop_mode_t;
endpackage

// >>> hdl/dcw_decoder.sv
// Operation
// - decode only when profile selection equals five
// - copy bus word into internal bits 0-15, reserved bit 3 dropped
// - bit0 stops with chosen mode, bit1 starts
// - bit2 reverses, else reference sign sets direction
// - bit4 rising edge resets active fault
// - bit5 picks second remote location if bus-sourced
// - bit6 high drops run enable if bus-sourced
// - bits7-9 pick stop mode, else parameter
// - bit10 low selects ramp set one
// - bit11 forces ramp output to zero
// - bit12 holds ramp output
// - bit13 forces ramp input to zero
// - bit14 blocks switching into local mode
// - bit16 takes control from bus locally
// - bit17 takes reference from bus locally
// - bits22-25 are four user flags
module dcw_decoder
    import dcw_pkg::*;
(
    input  wire logic        core_clk,          // system clock, 200 MHz
    input  wire logic        rstn,              // async reset, active low
    input  wire logic [7:0]  profile_sel,       // control profile parameter
    input  wire logic        cmd_wr,            // one-cycle write strobe of the word
    input  wire logic [31:0] cmd_wdata,         // word from the fieldbus master
    input  wire logic [1:0]  param_stop_mode,   // configured stop mode (dcw_stop_mode_t)
    input  wire logic        ref_negative,      // sign of the active reference
    input  wire logic        fault_active,      // drive has an active fault
    input  wire logic        loc_sel_from_bus,  // location selection sourced from bus
    input  wire logic        run_en_from_bus,   // run enable sourced from bus
    output logic [31:0]      drive_command_word, // internal command word readback
    output logic             stop_cmd,          // stop request level
    output logic [1:0]       stop_mode,         // effective stop mode
    output logic             start_cmd,         // start request level
    output logic             dir_reverse,       // 1 = reverse rotation
    output logic             fault_reset,       // one-cycle fault reset pulse
    output logic             second_remote_location, // remote location 2 selected
    output logic             first_remote_location,  // remote location 1 selected
    output logic             run_enable,        // run enable when bus-sourced
    output logic             normal_ramp_stop_req,
    output logic             emergency_ramp_stop_req,
    output logic             freewheel_stop_req,
    output logic             ramp_set1_sel,     // choose accel/decel time 1
    output logic             ramp_out_zero,     // force ramp output to zero
    output logic             ramp_hold,         // freeze ramp output
    output logic             ramp_in_zero,      // force ramp input to zero
    output logic             local_lock,        // refuse switch into local mode
    output logic             bus_control_takeover,
    output logic             bus_reference_takeover,
    output logic [3:0]       user_flags         // application user bits
);

    // latched word, registered fault reset, location and run enable
    logic [31:0] cmd_q;        // latched command word
    logic        fault_pulse;  // registered fault reset
    logic        loc2_q;       // last location choice, held when not bus-sourced
    logic        run_en_q;     // last run enable, held when not bus-sourced

    // decode only in the pass-through profile; other profiles leave the stored word unchanged, while dir_reverse and stop_mode follow their live inputs
    wire         profile_ok = (profile_sel == PROFILE_PASS_THRU);
    wire         take_word  = cmd_wr && profile_ok;
    // reserved bits are masked so a careless master changes nothing
    wire  [31:0] next_cmd   = take_word ? (cmd_wdata & CMD_USED_MASK) : cmd_q;
    // edge detect against the previously latched value
    wire         reset_rise = next_cmd[BIT_RESET] && !cmd_q[BIT_RESET];

    // stop mode: explicit request bits win in priority ramp, emergency, coast
    wire [2:0] stop_bits = cmd_q[BIT_STOP_FREE:BIT_STOP_RAMP];
    dcw_stop_mode_t next_stop_mode;
    assign next_stop_mode = stop_bits[0] ? DCW_STOP_RAMP :
                            stop_bits[1] ? DCW_STOP_EMER :
                            stop_bits[2] ? DCW_STOP_FREE :
                            dcw_stop_mode_t'(param_stop_mode);

    // word latch: one cycle from strobe to stored word
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q      <= CMD_RESET_VAL;
        end else begin
            cmd_q      <= next_cmd;
        end
    end

    // fault reset pulses only on a rising bit while a fault is present
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fault_pulse <= 1'b0;
        end else begin
            fault_pulse <= reset_rise && fault_active;
        end
    end

    // location and run enable follow the bus only when configured to
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            loc2_q   <= 1'b0;
            run_en_q <= 1'b0;
        end else begin
            if (loc_sel_from_bus) begin
                loc2_q <= cmd_q[BIT_LOC2];
            end
            if (run_en_from_bus) begin
                run_en_q <= !cmd_q[BIT_RUN_DIS];
            end
        end
    end

    // internal word: bits 0-15 copied as received except reserved bit 3, rest as defined bits
    assign drive_command_word = cmd_q;
    assign stop_cmd          = cmd_q[BIT_STOP];
    assign start_cmd         = cmd_q[BIT_START];
    assign stop_mode         = next_stop_mode;
    // reverse bit overrides; otherwise negative reference means reverse
    assign dir_reverse       = cmd_q[BIT_REVERSE] | ref_negative;
    assign fault_reset       = fault_pulse;
    assign second_remote_location = loc2_q;
    assign first_remote_location  = !loc2_q;
    assign run_enable        = run_en_q;
    assign normal_ramp_stop_req    = stop_bits[0];
    assign emergency_ramp_stop_req = stop_bits[1];
    assign freewheel_stop_req      = stop_bits[2];
    // a one in the ramp set bit is a no-op, so set 1 is simply not forced
    assign ramp_set1_sel     = !cmd_q[BIT_RAMP_SET];
    assign ramp_out_zero     = cmd_q[BIT_OUT_ZERO];
    assign ramp_hold         = cmd_q[BIT_HOLD];
    assign ramp_in_zero      = cmd_q[BIT_IN_ZERO];
    assign local_lock        = cmd_q[BIT_LOC_LOCK];
    assign bus_control_takeover   = cmd_q[BIT_CTL_TAKE];
    assign bus_reference_takeover = cmd_q[BIT_REF_TAKE];
    assign user_flags        = cmd_q[BIT_USER_LO +: 4];

    // checks on the latch and on every decoded level
    // they watch outputs and state, never the bench's own drive

    // an accepted write is visible one edge later, masked
    // a slower latch would let the control logic act on a stale word
    latch_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        take_word |=> cmd_q == ($past(cmd_wdata) & CMD_USED_MASK))
        else $error("word not latched in one cycle");

    // no strobe means the stored word keeps its value
    // a toggling bus between writes must not leak in
    hold_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !cmd_wr |=> $stable(cmd_q))
        else $error("word changed without a write");

    // outside the pass-through profile writes are dropped silently
    // the other profile needs conversion that this block lacks
    profile_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !profile_ok |=> $stable(cmd_q))
        else $error("word taken outside pass-through profile");

    // reserved bits never reach the stored word
    // they read back as zero whatever the master sent
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (cmd_q & ~CMD_USED_MASK) == 32'h0000_0000)
        else $error("reserved bit stored");

    // the low half of the word passes unchanged apart from bit 3
    // no scaling or conversion is applied
    copy_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
        take_word |=> drive_command_word[15:0] == ($past(cmd_wdata[15:0]) & CMD_USED_MASK[15:0]))
        else $error("low half of word not copied");

    // stop level follows its bit in the readback word
    // a zero is a no-op, so the level simply drops
    stop_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stop_cmd == drive_command_word[BIT_STOP])
        else $error("stop level wrong");

    // start level follows its bit in the readback word
    // the control logic owns any start interlocks
    start_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_cmd == drive_command_word[BIT_START])
        else $error("start level wrong");

    // a pulse needs a rising reset bit and a fault in the write cycle
    // a held-high bit must not keep clearing new faults
    fault_edge_a: assert property (@(posedge core_clk) disable iff (!rstn)
        fault_reset |-> $past(cmd_q[BIT_RESET], 1) == 1'b0 && cmd_q[BIT_RESET] && $past(fault_active))
        else $error("fault reset without rising edge");

    // a rising edge with a fault gives the pulse at the next edge
    // the pulse is registered, so it lags the edge by one cycle
    fault_fire_a: assert property (@(posedge core_clk) disable iff (!rstn)
        reset_rise && fault_active |=> fault_reset)
        else $error("fault reset missed");

    // the pulse lasts one cycle only
    // a second write of the same bit is no new edge
    fault_once_a: assert property (@(posedge core_clk) disable iff (!rstn)
        fault_reset |=> !fault_reset)
        else $error("fault reset longer than one cycle");

    // no request bit set falls back to the configured stop mode
    // the parameter is a live input, so no delay is involved
    stop_prio_a: assert property (@(posedge core_clk) disable iff (!rstn)
        stop_bits == 3'h0 |-> stop_mode == param_stop_mode)
        else $error("stop mode fallback wrong");

    // normal ramp request wins over the other two
    // the order among several set bits is a local choice
    stop_ramp_a: assert property (@(posedge core_clk) disable iff (!rstn)
        drive_command_word[BIT_STOP_RAMP] |-> stop_mode == DCW_STOP_RAMP)
        else $error("normal ramp stop not chosen");

    // emergency ramp when it is the highest set request
    // it still stops within the drive's own limits
    stop_emer_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !drive_command_word[BIT_STOP_RAMP] && drive_command_word[BIT_STOP_EMER] |-> stop_mode == DCW_STOP_EMER)
        else $error("emergency ramp stop not chosen");

    // coast only when it is the sole request
    // the motor then runs down with no braking
    stop_free_a: assert property (@(posedge core_clk) disable iff (!rstn)
        drive_command_word[BIT_STOP_FREE:BIT_STOP_RAMP] == 3'h4 |-> stop_mode == DCW_STOP_FREE)
        else $error("coast stop not chosen");

    // request outputs mirror the three bits of the word
    // the control logic may read them apart from the mode
    stop_reqs_a: assert property (@(posedge core_clk) disable iff (!rstn)
        {freewheel_stop_req, emergency_ramp_stop_req, normal_ramp_stop_req}
            == drive_command_word[BIT_STOP_FREE:BIT_STOP_RAMP])
        else $error("stop request outputs wrong");

    // bus-sourced run enable is the inverse of the disable bit
    // it lags the word by one register stage
    run_en_a: assert property (@(posedge core_clk) disable iff (!rstn)
        run_en_from_bus |=> run_enable == !$past(cmd_q[BIT_RUN_DIS]))
        else $error("run enable does not follow bit");

    // another run enable source freezes the bus value
    // no other source is modelled inside this block
    run_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !run_en_from_bus |=> $stable(run_enable))
        else $error("run enable changed while not bus-sourced");

    // bus-sourced location follows the location bit
    // it lags the word by one register stage
    loc_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        loc_sel_from_bus |=> second_remote_location == $past(cmd_q[BIT_LOC2]))
        else $error("location does not follow bit");

    // another location source freezes the bus choice
    // the last chosen location stays in force
    loc_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !loc_sel_from_bus |=> $stable(second_remote_location))
        else $error("location changed while not bus-sourced");

    // exactly one remote location is selected at a time
    // both at once would leave the control source ambiguous
    loc_onehot_a: assert property (@(posedge core_clk) disable iff (!rstn)
        second_remote_location != first_remote_location)
        else $error("location outputs not exclusive");

    // a set reverse bit always reverses
    // the reference sign cannot override it
    dir_rev_a: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_q[BIT_REVERSE] |-> dir_reverse)
        else $error("reverse bit ignored");

    // a clear reverse bit leaves direction to the reference sign
    // the sign is a live input from the reference path
    dir_sign_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !cmd_q[BIT_REVERSE] |-> dir_reverse == ref_negative)
        else $error("direction does not follow reference sign");

    // ramp set one is chosen while its bit is low
    // a high bit forces nothing, the ramp logic decides
    ramp_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_set1_sel == !drive_command_word[BIT_RAMP_SET])
        else $error("ramp set selection wrong");

    // ramp output forced to zero while its bit is high
    // current and voltage limits stay with the drive
    ramp_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_out_zero == drive_command_word[BIT_OUT_ZERO])
        else $error("ramp output zero wrong");

    // ramp output frozen while its bit is high
    // the frozen value itself lives in the ramp logic
    ramp_freeze_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_hold == drive_command_word[BIT_HOLD])
        else $error("ramp hold wrong");

    // ramp input forced to zero while its bit is high
    // the output then ramps down at the active rate
    ramp_input_a: assert property (@(posedge core_clk) disable iff (!rstn)
        ramp_in_zero == drive_command_word[BIT_IN_ZERO])
        else $error("ramp input zero wrong");

    // switching into local mode refused while the lock bit is high
    // a drive already in local mode is not thrown out
    local_lock_a: assert property (@(posedge core_clk) disable iff (!rstn)
        local_lock == drive_command_word[BIT_LOC_LOCK])
        else $error("local lock wrong");

    // control takeover follows its bit
    // it overrides the active control source while set
    ctl_take_a: assert property (@(posedge core_clk) disable iff (!rstn)
        bus_control_takeover == drive_command_word[BIT_CTL_TAKE])
        else $error("control takeover wrong");

    // reference takeover follows its bit
    // it overrides the active reference source while set
    ref_take_a: assert property (@(posedge core_clk) disable iff (!rstn)
        bus_reference_takeover == drive_command_word[BIT_REF_TAKE])
        else $error("reference takeover wrong");

    // user flags carry the four user bits unchanged
    // they have no built-in action here
    user_bits_a: assert property (@(posedge core_clk) disable iff (!rstn)
        user_flags == drive_command_word[BIT_USER_LO +: 4])
        else $error("user flags wrong");

    // main scenarios worth seeing at least once
    start_c: cover property (@(posedge core_clk) disable iff (!rstn) start_cmd ##[1:20] stop_cmd);
    freset_c: cover property (@(posedge core_clk) disable iff (!rstn) fault_reset);
    takeover_c: cover property (@(posedge core_clk) disable iff (!rstn)
        bus_control_takeover && bus_reference_takeover);
    emer_stop_c: cover property (@(posedge core_clk) disable iff (!rstn)
        stop_cmd && stop_mode == DCW_STOP_EMER);
    loc_switch_c: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(second_remote_location));
endmodule

// >>> tb/dcw_master.sv
// fieldbus master model: turns a bench request into a one-cycle word write
module dcw_master
    import dcw_pkg::*;
(
    input  wire logic        core_clk,   // system clock
    input  wire logic        req,        // bench asks for one write
    input  wire logic [31:0] req_word,   // word to send
    input  wire logic        raw,        // send reserved bits as given (fault case)
    output logic             cmd_wr,     // write strobe
    output logic [31:0]      cmd_wdata   // word on the bus
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_wr    = 1'b0;
        cmd_wdata = 32'h0000_0000;
    end
    // data toggles outside the strobe so a stale word is never mistaken for valid
    always @(posedge core_clk) begin
        cmd_wr <= req;
        if (req) begin
            cmd_wdata <= raw ? req_word : (req_word & CMD_USED_MASK);
        end else begin
            cmd_wdata <= ~cmd_wdata;
        end
    end
endmodule

// >>> tb/dcw_decoder_bench.sv
module dcw_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcw_pkg::*;
`define CHK(n,e,g) begin check_count++; if ((g)!==(e)) begin error_cnt++; $display("ERROR %s exp %h got %h",n,e,g); end end
    logic        core_clk = 0, rstn = 0, req = 0, raw = 0, fa = 0, rn = 0, lsb = 0, rsb = 0;
    logic [7:0]  ps = 8'h05;   // profile selection
    logic [1:0]  psm = 2'h0;   // configured stop mode
    logic [31:0] rw = 0, em = 0, eo, cmd_wdata, drive_command_word;
    logic        eloc = 0, erun = 0, efr, cmd_wr, stop_cmd, start_cmd, dir_reverse, fault_reset;
    logic        second_remote_location, first_remote_location, run_enable, normal_ramp_stop_req;
    logic        emergency_ramp_stop_req, freewheel_stop_req, ramp_set1_sel, ramp_out_zero, ramp_hold;
    logic        ramp_in_zero, local_lock, bus_control_takeover, bus_reference_takeover;
    logic [1:0]  stop_mode;
    logic [3:0]  user_flags;
    int          error_cnt = 0, check_count = 0;
    always #2.5 core_clk = ~core_clk;
    dcw_master i_master (.core_clk(core_clk), .req(req), .req_word(rw), .raw(raw), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata));
    dcw_decoder i_dut (.*, .profile_sel(ps), .param_stop_mode(psm), .ref_negative(rn), .fault_active(fa),
        .loc_sel_from_bus(lsb), .run_en_from_bus(rsb));
    // request bits win in order ramp, emergency, coast; otherwise the parameter
    function automatic logic [1:0] smode(input logic [31:0] w);
        return w[7] ? 2'h1 : w[8] ? 2'h2 : w[9] ? 2'h3 : psm;
    endfunction
    // compare every output against the expected word
    task automatic chk;
        if (lsb) eloc = em[5];
        if (rsb) erun = ~em[6];
        `CHK("word", em, drive_command_word)
        `CHK("stop", {em[0], smode(em), em[1]}, {stop_cmd, stop_mode, start_cmd})
        `CHK("dir", em[2] | rn, dir_reverse)
        `CHK("fault_reset", efr, fault_reset)
        `CHK("location", {eloc, ~eloc}, {second_remote_location, first_remote_location})
        `CHK("run_enable", erun, run_enable)
        `CHK("stop_reqs", em[9:7], {freewheel_stop_req, emergency_ramp_stop_req, normal_ramp_stop_req})
        `CHK("ramp", {~em[10], em[13:11]}, {ramp_set1_sel, ramp_in_zero, ramp_hold, ramp_out_zero})
        `CHK("local", {em[14], em[16], em[17]}, {local_lock, bus_control_takeover, bus_reference_takeover})
        `CHK("user", em[25:22], user_flags)
    endtask
    // one write through the master; side inputs are drawn fresh and held
    task automatic wr(input logic [31:0] w, input logic [7:0] p, input logic f, input logic r);
        @(posedge core_clk);
        req <= 1'b1;
        rw  <= w;
        raw <= r;
        ps  <= p;
        fa  <= f;
        psm <= 2'($urandom);
        rn  <= 1'($urandom);
        lsb <= 1'($urandom);
        rsb <= 1'($urandom);
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        #1;
        eo = em;
        if (p === PROFILE_PASS_THRU) em = w & CMD_USED_MASK;
        efr = (p === PROFILE_PASS_THRU) & em[4] & ~eo[4] & f;
        `CHK("fault_pulse", efr, fault_reset)
        @(posedge core_clk);
        #1;
        efr = 1'b0;
        chk();
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // corner cases first, then random words, some with a wrong profile
    initial begin
        void'($urandom(32'h2ca6));
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        efr = 1'b0;
        chk();
        wr(32'h0, 8'h05, 1, 0);
        wr(32'h10, 8'h05, 1, 0);
        wr(32'h10, 8'h05, 1, 0);
        wr(32'h0, 8'h05, 1, 0);
        wr(32'h10, 8'h05, 0, 0);
        wr(32'h81, 8'h05, 0, 0);
        wr(32'h181, 8'h05, 0, 0);
        wr(32'h301, 8'h05, 0, 0);
        wr(32'h201, 8'h05, 0, 0);
        wr(32'h1, 8'h05, 0, 0);
        wr(32'hffff_ffff, 8'h05, 1, 1);
        wr(32'h0, 8'h04, 1, 0);
        repeat (200) wr($urandom, ($urandom % 4 == 0) ? 8'($urandom) : 8'h05, 1'($urandom), 1'($urandom));
        conclude();
    end
    // hang guard: about 20000 cycles, far beyond the planned run
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule
